// ---- dv/tim_core_monitor.sv ----
// port checker for the instruction timing sequencer
`timescale 1ns/100ps
`default_nettype none
module tim_core_monitor
  import tim_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        resetn,
  input wire logic [tim_pkg::ADDR_W-1:0]  pm_addr,
  input wire logic                        pm_rd,
  input wire logic [7:0]                  pm_data,
  input wire logic                        branch_taken,
  input wire logic [tim_pkg::ADDR_W-1:0]  branch_target,
  input wire logic                        debug_halt,
  input wire logic                        opcode_fetch,
  input wire logic [tim_pkg::PHASE_W-1:0] phase,
  input wire logic                        retire_valid,
  input wire tim_pkg::tim_retire_s        retire,
  input wire logic                        halted
);
  // ==========================================================
  // timing checks, all in the one clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_halt_req;
    pm_rd && opcode_fetch && phase == PHASE_FIRST && debug_halt;
  endsequence
  sequence s_halted;
    halted && !pm_rd;
  endsequence
  // fixed opcodes carry a fixed byte and clock count
  property p_op(logic [7:0] op, logic [1:0] b, logic [3:0] c);
    retire_valid && retire.opcode == op |->
      retire.bytes == b && retire.cycles == c;
  endproperty
  a_retire_boundary: assert property (retire_valid |->
    phase == PHASE_FIRST && {1'b0, $past(phase)} + 4'h1 == retire.cycles)
    else $error("retire count differs from clocks spent");
  a_cycle_bound: assert property (retire_valid |->
    retire.cycles != 4'h0 && retire.cycles <= MAX_CYCLES)
    else $error("instruction clock count out of range");
  a_bytes_le_cycles: assert property (retire_valid |->
    retire.bytes <= retire.cycles)
    else $error("fewer clocks than program bytes");
  a_branch_extra: assert property (retire_valid &&
    retire.opcode == 8'h60 |-> retire.cycles == (retire.taken ? 4'h3 : 4'h2))
    else $error("conditional branch count wrong");
  a_mul_clocks: assert property (p_op(8'ha4, 2'h1, 4'h4))
    else $error("multiply timing wrong");
  a_div_clocks: assert property (p_op(8'h84, 2'h1, 4'h8))
    else $error("divide timing wrong");
  a_ret_clocks: assert property (p_op(8'h22, 2'h1, 4'h5))
    else $error("return timing wrong");
  a_reti_clocks: assert property (p_op(8'h32, 2'h1, 4'h5))
    else $error("interrupt return timing wrong");
  a_call_clocks: assert property (p_op(8'h12, 2'h3, 4'h4))
    else $error("long call timing wrong");
  a_halt_enter: assert property (s_halt_req |=> s_halted)
    else $error("halt not entered at boundary");
  a_halt_freeze: assert property (halted && $past(halted) |->
    $stable(pm_addr) && !retire_valid)
    else $error("state moved while halted");
endmodule
`default_nettype wire

// ---- dv/tim_pmem_model.sv ----
// program memory model with same-cycle read
`timescale 1ns/100ps
`default_nettype none
module tim_pmem_model
  import tim_pkg::*;
(
  input wire logic [tim_pkg::ADDR_W-1:0] pm_addr,
  input wire logic                       pm_rd,
  output logic [7:0]                     pm_data
);
  logic [7:0] mem [0:255];
  logic [7:0] rd_byte;
  logic [7:0] last_q = 8'h00;
  // ==========================================================
  // read path; only 256 bytes, addresses wrap
  assign rd_byte = mem[pm_addr[7:0]];
  // released bus shows the inverse, so a stale byte never passes
  always @(negedge pm_rd) last_q = rd_byte;
  assign pm_data = pm_rd ? rd_byte : ~last_q;
endmodule
`default_nettype wire

// ---- dv/tim_tb.sv ----
// self-checking bench for the timing sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  import tim_pkg::*;
  localparam int NR = 22;
  // rows: opcode, bytes, clocks, branch result, redirect target
  localparam logic [27:0] ROWS [NR] = '{
    28'h28_1_1_0_00, 28'h25_2_2_0_00, 28'h26_1_2_0_00, 28'h24_2_2_0_00,
    28'h38_1_1_0_00, 28'h36_1_2_0_00, 28'h94_2_2_0_00, 28'h96_1_2_0_00,
    28'h52_2_2_0_00, 28'h53_3_3_1_00, 28'h43_3_3_0_00, 28'h62_2_2_0_00,
    28'h56_1_2_0_00, 28'h68_1_1_0_00, 28'h46_1_2_0_00, 28'ha4_1_4_0_00,
    28'h84_1_8_0_00, 28'h60_2_2_0_00, 28'h60_2_3_1_80, 28'h12_3_4_0_90,
    28'h22_1_5_0_a0, 28'h32_1_5_0_b0};
  logic        clk, resetn, branch_taken, debug_halt, pm_rd;
  logic        opcode_fetch, retire_valid, halted;
  logic [15:0] branch_target, pm_addr, a, adr_q [NR+1];
  logic [7:0]  pm_data;
  logic [2:0]  phase;
  logic [27:0] r;
  tim_retire_s retire;
  int          fail_count, comparisons, i;
  // ==========================================================
  // clock and instances
  always #2 clk = ~clk;
  tim_core uut (.clk(clk), .resetn(resetn), .pm_addr(pm_addr),
    .pm_rd(pm_rd), .pm_data(pm_data), .branch_taken(branch_taken),
    .branch_target(branch_target), .debug_halt(debug_halt),
    .opcode_fetch(opcode_fetch), .phase(phase),
    .retire_valid(retire_valid), .retire(retire), .halted(halted));
  tim_pmem_model u_pm (.pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data));
  // ==========================================================
  // shared tasks
  task chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      $display("Error t=%0t got %h exp %h", $time, g, e);
      fail_count++;
    end
  endtask
  task end_sim;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // bounded wait: 0 for retire, 1 for halted
  task automatic wait_hi(input bit h);
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      #1;
      if ((h ? halted : retire_valid) === 1'b1) return;
    end
    fail_count++;
    $display("Error t=%0t wait got %h exp %h", $time, 1'b0, 1'b1);
    end_sim;
  endtask
  // branch inputs only matter in the row's own last clocks
  task set_row(input int k);
    r = ROWS[k];
    branch_taken = r[8];
    branch_target = {8'h00, r[7:0]};
  endtask
  // ==========================================================
  // main sequence
  initial begin
    clk = 0; resetn = 0; debug_halt = 0; fail_count = 0; comparisons = 0;
    for (i = 0; i < 256; i++) u_pm.mem[i] = 8'h00;
    a = 16'h0000;
    for (i = 0; i < NR; i++) begin
      r = ROWS[i];
      adr_q[i] = a;
      u_pm.mem[a[7:0]] = r[27:20];
      if (r[19:16] > 1) u_pm.mem[a[7:0] + 8'h1] = 8'hc3;
      if (r[19:16] > 2) u_pm.mem[a[7:0] + 8'h2] = 8'h3c;
      a = (r[7:0] != 0) ? {8'h00, r[7:0]} : a + 16'(r[19:16]);
    end
    adr_q[NR] = a;
    set_row(0);
    repeat (2) @(posedge clk);
    #1 resetn = 1;
    for (i = 0; i < NR; i++) begin
      wait_hi(0);
      chk(16'(retire.opcode), 16'(r[27:20]));
      chk(16'(retire.bytes), 16'(r[19:16]));
      chk(16'(retire.cycles), 16'(r[15:12]));
      chk(16'(retire.taken), 16'(r[7:0] != 0));
      if (r[19:16] > 1) chk(16'(retire.op1), 16'h00c3);
      if (r[19:16] > 2) chk(16'(retire.op2), 16'h003c);
      chk(pm_addr, adr_q[i+1]);
      if (i + 1 < NR) set_row(i + 1);
    end
    $display("test table done");
    // halt raised at a boundary freezes the fetch address
    debug_halt = 1;
    wait_hi(1);
    chk(16'(pm_rd), 16'h0000);
    a = pm_addr;
    repeat (3) @(posedge clk);
    #1 chk(pm_addr, a);
    debug_halt = 0;
    @(posedge clk);
    #1 chk(16'(halted), 16'h0000);
    chk(16'(pm_rd), 16'h0001);
    chk(pm_addr, a);
    $display("test halt done");
    // reset in mid-run, then restart from address zero
    resetn = 0;
    #1 chk(16'(pm_rd), 16'h0000);
    chk(16'(retire_valid), 16'h0000);
    chk(16'(phase), 16'h0000);
    chk(pm_addr, RESET_PC);
    repeat (2) @(posedge clk);
    #1 resetn = 1;
    @(posedge clk);
    #1 chk(16'(opcode_fetch), 16'h0001);
    chk(pm_addr, RESET_PC);
    $display("test reset done");
    // halt raised inside a two-clock op waits for its boundary
    repeat (2) @(posedge clk);
    #1 debug_halt = 1;
    @(posedge clk);
    #1 chk(16'(halted), 16'h0000);
    wait_hi(1);
    chk(pm_addr, adr_q[2]);
    $display("test late halt done");
    end_sim;
  end
endmodule
bind tim_core tim_core_monitor u_mon (.clk(clk), .resetn(resetn),
  .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data),
  .branch_taken(branch_taken), .branch_target(branch_target),
  .debug_halt(debug_halt), .opcode_fetch(opcode_fetch), .phase(phase),
  .retire_valid(retire_valid), .retire(retire), .halted(halted));
`default_nettype wire

// ---- hw/tim_core.sv ----
// pipelined instruction timing sequencer of the 8-bit core
// Summary of operation
// - everything is counted in single system clocks, no machine cycles
// - most instructions take one or two clocks, none more than eight
// - 109 instructions; 26 take one clock, 50 take two
// - runs at any clock up to 50 MHz, one instruction per clock peak
// - standard opcodes, modes and flag effects; only timing differs
// - most instructions take one clock per program byte
// - untaken conditional branch finishes one clock before a taken one
// - add: register 1/1, direct or immediate 2/2, indirect 1/2
// - add-with-carry and subtract-with-borrow follow add; indirect 1/2
// - logic into direct byte: from accumulator 2/2, immediate 3/3
// - logic into accumulator: indirect source 1/2, register 1/1
// - debug halt uses no user RAM, stack or timers, alters nothing
// - returns take one byte, five clocks; long call three bytes, four
`timescale 1ns/100ps
`default_nettype none

module tim_core
  import tim_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 resetn,
  output logic [tim_pkg::ADDR_W-1:0] pm_addr,
  output logic                      pm_rd,
  input  wire logic [7:0]           pm_data,
  input  wire logic                 branch_taken,
  input  wire logic [tim_pkg::ADDR_W-1:0] branch_target,
  input  wire logic                 debug_halt,
  output logic                      opcode_fetch,
  output logic [tim_pkg::PHASE_W-1:0] phase,
  output logic                      retire_valid,
  output tim_pkg::tim_retire_s      retire,
  output logic                      halted
);
  import tim_pkg::*;

  // ==========================================================
  // opcode timing table
  // flag and data effects live in the datapath; only clocks here
  function automatic tim_dec_s tim_decode(input logic [7:0] op);
    tim_dec_s   d;
    logic [3:0] hi;
    logic [3:0] lo;
    hi = op[7:4];
    lo = op[3:0];
    d  = tim_mk(2'h1, 4'h1, 1'b0, 1'b0);
    if (lo[3]) begin
      // register operand forms
      case (hi)
        4'h7, 4'h8, 4'ha: d = tim_mk(2'h2, 4'h2, 1'b0, 1'b0);
        4'hb:             d = tim_mk(2'h3, 4'h3, 1'b1, 1'b0);
        4'hd:             d = tim_mk(2'h2, 4'h2, 1'b1, 1'b0);
        default:          d = tim_mk(2'h1, 4'h1, 1'b0, 1'b0);
      endcase
    end else if (lo[3:1] == 3'h3) begin
      // indirect_register_operand forms
      case (hi)
        4'h7, 4'h8, 4'ha: d = tim_mk(2'h2, 4'h2, 1'b0, 1'b0);
        4'hb:             d = tim_mk(2'h3, 4'h4, 1'b1, 1'b0);
        default:          d = tim_mk(2'h1, 4'h2, 1'b0, 1'b0);
      endcase
    end else if (lo == 4'h5) begin
      // direct operand forms
      case (hi)
        4'h7, 4'h8: d = tim_mk(2'h3, 4'h3, 1'b0, 1'b0);
        4'ha:       d = tim_mk(2'h1, 4'h1, 1'b0, 1'b0);
        4'hb:       d = tim_mk(2'h3, 4'h4, 1'b1, 1'b0);
        4'hd:       d = tim_mk(2'h3, 4'h3, 1'b1, 1'b0);
        default:    d = tim_mk(2'h2, 4'h2, 1'b0, 1'b0);
      endcase
    end else if (lo == 4'h4) begin
      // immediate and accumulator forms
      case (hi)
        4'h0, 4'h1, 4'hc, 4'hd, 4'he, 4'hf:
                 d = tim_mk(2'h1, 4'h1, 1'b0, 1'b0);
        4'h8:    d = tim_mk(2'h1, MAX_CYCLES, 1'b0, 1'b0);
        4'ha:    d = tim_mk(2'h1, 4'h4, 1'b0, 1'b0);
        4'hb:    d = tim_mk(2'h3, 4'h3, 1'b1, 1'b0);
        default: d = tim_mk(2'h2, 4'h2, 1'b0, 1'b0);
      endcase
    end else if (lo == 4'h3) begin
      case (hi)
        4'h0, 4'h1, 4'h2, 4'h3, 4'ha, 4'hb, 4'hc, 4'hd:
                 d = tim_mk(2'h1, 4'h1, 1'b0, 1'b0);
        4'h4, 4'h5, 4'h6:
                 d = tim_mk(2'h3, 4'h3, 1'b0, 1'b0);
        4'h7:    d = tim_mk(2'h1, 4'h3, 1'b0, 1'b1);
        default: d = tim_mk(2'h1, 4'h3, 1'b0, 1'b0);
      endcase
    end else if (lo == 4'h2) begin
      case (hi)
        4'h0, 4'h1: d = tim_mk(2'h3, 4'h4, 1'b0, 1'b1);
        4'h2, 4'h3: d = tim_mk(2'h1, 4'h5, 1'b0, 1'b1);
        4'he, 4'hf: d = tim_mk(2'h1, 4'h3, 1'b0, 1'b0);
        default:    d = tim_mk(2'h2, 4'h2, 1'b0, 1'b0);
      endcase
    end else if (lo == 4'h1) begin
      // absolute jump and call
      d = tim_mk(2'h2, 4'h3, 1'b0, 1'b1);
    end else begin
      case (hi)
        4'h0:             d = tim_mk(2'h1, 4'h1, 1'b0, 1'b0);
        4'h1, 4'h2, 4'h3: d = tim_mk(2'h3, 4'h3, 1'b1, 1'b0);
        4'h4, 4'h5, 4'h6, 4'h7:
                          d = tim_mk(2'h2, 4'h2, 1'b1, 1'b0);
        4'h8:             d = tim_mk(2'h2, 4'h3, 1'b0, 1'b1);
        4'h9:             d = tim_mk(2'h3, 4'h3, 1'b0, 1'b0);
        4'he, 4'hf:       d = tim_mk(2'h1, 4'h3, 1'b0, 1'b0);
        default:          d = tim_mk(2'h2, 4'h2, 1'b0, 1'b0);
      endcase
    end
    return d;
  endfunction

  // ==========================================================
  // state
  tim_state_e             state_reg;
  tim_state_e             state_next;
  logic [ADDR_W-1:0]      pc_reg;
  logic [PHASE_W-1:0]     phase_reg;
  tim_dec_s               info_reg;
  logic                   ext_reg;
  tim_retire_s            rec_reg;
  tim_retire_s            rec_next;
  logic                   pm_rd_reg;
  logic                   opf_reg;
  logic                   rv_reg;
  tim_retire_s            ret_reg;
  logic                   halted_reg;

  tim_dec_s               dec_now;
  tim_dec_s               cur;
  logic                   at_first;
  logic                   step;
  logic                   base_last;
  logic                   extend;
  logic                   last;
  logic                   redirect;
  logic                   byte_cyc;
  logic [3:0]             phase4;

  // ==========================================================
  // current instruction view
  // the opcode clock decodes the byte straight off the bus
  assign dec_now   = tim_decode(pm_data);
  assign at_first  = (phase_reg == PHASE_FIRST);
  assign cur       = at_first ? dec_now : info_reg;
  assign phase4    = {1'b0, phase_reg};
  assign step      = (state_reg == ST_RUN) && !(at_first && debug_halt);
  assign base_last = (phase4 == cur.cycles - 4'h1);
  assign extend    = base_last && cur.cond && branch_taken;
  assign last      = (base_last && !extend) || ext_reg;
  assign redirect  = last && (cur.jump || ext_reg);
  assign byte_cyc  = (phase4 < {2'b00, cur.bytes});

  // ==========================================================
  // sequencer state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_BOOT: state_next = ST_RUN;
      ST_RUN: begin
        if (at_first && debug_halt) begin
          state_next = ST_HALT;
        end
      end
      ST_HALT: begin
        if (!debug_halt) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_BOOT;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_BOOT;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // program counter: one byte per clock until the bytes are fetched, target on redirect
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc_reg <= RESET_PC;
    end else if (step) begin
      if (redirect) begin
        pc_reg <= branch_target;
      end else if (byte_cyc) begin
        pc_reg <= pc_reg + 16'h0001;
      end
    end
  end

  // ==========================================================
  // phase counter; back-to-back single-clock ops give one per clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= PHASE_FIRST;
      ext_reg   <= 1'b0;
    end else if (step) begin
      phase_reg <= last ? PHASE_FIRST : phase_reg + 3'h1;
      ext_reg   <= extend;
    end
  end

  // decoded timing held for the later clocks of the instruction
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      info_reg <= '0;
    end else if (step && at_first) begin
      info_reg <= dec_now;
    end
  end

  // ==========================================================
  // instruction record: opcode and operand bytes as they stream in
  always_comb begin
    rec_next = rec_reg;
    if (at_first) begin
      rec_next        = '0;
      rec_next.opcode = pm_data;
      rec_next.bytes  = dec_now.bytes;
    end else if (phase_reg == PHASE_OP1 && byte_cyc) begin
      rec_next.op1 = pm_data;
    end else if (phase_reg == PHASE_OP2 && byte_cyc) begin
      rec_next.op2 = pm_data;
    end
    rec_next.cycles = phase4 + 4'h1;
    rec_next.taken  = redirect;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rec_reg <= '0;
    end else if (step) begin
      rec_reg <= rec_next;
    end
  end

  // ==========================================================
  // retire strobe and record, one clock after the final clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rv_reg  <= 1'b0;
      ret_reg <= '0;
    end else begin
      rv_reg <= step && last;
      if (step && last) begin
        ret_reg <= rec_next;
      end
    end
  end

  // ==========================================================
  // bus strobes; halt only at a boundary, so nothing is half done
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pm_rd_reg  <= 1'b0;
      opf_reg    <= 1'b0;
      halted_reg <= 1'b0;
    end else begin
      pm_rd_reg  <= (state_next == ST_RUN);
      opf_reg    <= (state_next == ST_RUN) && (step ? last : at_first);
      halted_reg <= (state_next == ST_HALT);
    end
  end

  assign pm_addr      = pc_reg;
  assign pm_rd        = pm_rd_reg;
  assign opcode_fetch = opf_reg;
  assign phase        = phase_reg;
  assign retire_valid = rv_reg;
  assign retire       = ret_reg;
  assign halted       = halted_reg;

endmodule

`default_nettype wire

// ---- hw/tim_pkg.sv ----
// package of constants and types for the instruction timing sequencer
package tim_pkg;

  // ==========================================================
  // widths and reset values
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned PHASE_W     = 3;
  localparam logic [15:0] RESET_PC    = 16'h0000;
  localparam logic [3:0]  MAX_CYCLES  = 4'h8;
  localparam logic [2:0]  PHASE_FIRST = 3'h0;
  localparam logic [2:0]  PHASE_OP1   = 3'h1;
  localparam logic [2:0]  PHASE_OP2   = 3'h2;

  // ==========================================================
  // timing constants
  localparam int unsigned CLK_PERIOD_PS  = 4000;
  localparam int unsigned CORE_FMAX_MHZ  = 50;
  localparam int unsigned PEAK_MIPS      = 50;

  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_RUN  = 2'b01,
    ST_HALT = 2'b10
  } tim_state_e;

  // per-opcode timing: bytes, base clocks, conditional, redirect
  typedef struct packed {
    logic [1:0] bytes;
    logic [3:0] cycles;
    logic       cond;
    logic       jump;
  } tim_dec_s;

  // record of one finished instruction
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] op1;
    logic [7:0] op2;
    logic [1:0] bytes;
    logic [3:0] cycles;
    logic       taken;
  } tim_retire_s;

  function automatic tim_dec_s tim_mk(input logic [1:0] b,
                                      input logic [3:0] c,
                                      input logic       cnd,
                                      input logic       jmp);
    tim_dec_s d;
    d.bytes  = b;
    d.cycles = c;
    d.cond   = cnd;
    d.jump   = jmp;
    return d;
  endfunction

endpackage
